// file: hw/fault_log_pkg.sv
/*
 * Package for the fault log and event reporter: register offsets, field
 * positions, reset values, state encodings and sizing constants.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package fault_log_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] off_capability   = 12'h000;
	localparam logic [11:0] off_log_control  = 12'h004;
	localparam logic [11:0] off_log_base     = 12'h008;
	localparam logic [11:0] off_log_size     = 12'h00C;
	localparam logic [11:0] off_fault_status = 12'h010;
	localparam logic [11:0] off_event_ctrl   = 12'h014;
	localparam logic [11:0] off_event_data   = 12'h018;
	localparam logic [11:0] off_event_addr   = 12'h01C;
	localparam logic [11:0] off_log_index    = 12'h020;

	// ==========================================================
	// Capability bits
	localparam int cap_mem_log_bit  = 0;
	localparam int cap_compress_bit = 1;

	// Log control bits
	localparam int ctl_log_enable_bit = 0;
	localparam int ctl_new_region_bit = 1;

	// Fault status bits, write one to clear
	localparam int st_primary_overflow_bit     = 0;
	localparam int st_primary_pending_bit      = 1;
	localparam int st_mem_log_overflow_bit     = 2;
	localparam int st_mem_log_pending_bit      = 3;
	localparam int st_inval_queue_err_bit      = 4;
	localparam int st_inval_completion_err_bit = 5;
	localparam int st_inval_timeout_err_bit    = 6;
	localparam int st_width                    = 7;

	// Event control bits
	localparam int ev_irq_held_pending_bit = 30;
	localparam int ev_irq_mask_bit         = 31;

	// ==========================================================
	// Reset values
	localparam logic [31:0] log_base_reset = 32'h0000_0000;
	localparam logic [15:0] log_size_reset = 16'h0001;
	localparam logic [31:0] zero_word      = 32'h0000_0000;

	// ==========================================================
	// Memory write state machine
	typedef enum logic [1:0] {
		mw_idle  = 2'b00,
		mw_write = 2'b01,
		mw_msi   = 2'b10
	} mem_state_t;

endpackage

// file: hw/fault_log_and_event_reporter.sv
/*
 * Memory-resident fault logging and fault event reporting.
 * Assumes an APB master on pclk, a fault source giving a one-cycle strobe
 * with a source id, and a memory write port with valid/ready handshake
 * that carries both fault records and the fault event message.
 */
module fault_log_and_event_reporter #(
	parameter int          IDX_W         = 16,
	parameter int          SID_W         = 16,
	parameter logic [31:0] RECORD_BYTES  = 32'h0000_0010,
	parameter bit          HAS_COMPRESS  = 1'b1
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Fault sources
	input  wire logic              fault_valid,
	input  wire logic [SID_W-1:0]  fault_sid,
	input  wire logic              primary_pending_set,
	input  wire logic              primary_overflow_set,
	input  wire logic              inval_queue_set,
	input  wire logic              inval_completion_set,
	input  wire logic              inval_timeout_set,
	// Memory write port, records and messages
	output logic                   mem_valid,
	output logic      [31:0]       mem_addr,
	output logic      [31:0]       mem_data,
	output logic                   mem_is_msi,
	input  wire logic              mem_ready
);

	// ==========================================================
	// Registers and state
	localparam int st_width = fault_log_pkg::st_width;

	logic                     log_enable;
	logic [31:0]              log_base;
	logic [IDX_W-1:0]         log_size;
	logic [IDX_W-1:0]         log_index;
	logic                     log_wrapped;
	logic                     sid_valid;
	logic [SID_W-1:0]         last_sid;
	logic [st_width-1:0]      status;
	logic                     irq_mask;
	logic                     irq_held_pending;
	logic [31:0]              ev_data;
	logic [31:0]              ev_addr;
	fault_log_pkg::mem_state_t mem_state;
	logic                     msi_request;

	// ==========================================================
	// Bus decode
	logic bus_setup;
	logic bus_wr;
	logic bus_rd;
	logic mem_busy;
	logic new_region;
	logic [st_width-1:0] st_w1c;
	logic mask_wr;

	assign bus_setup = psel & ~penable;
	assign mem_busy  = (mem_state != fault_log_pkg::mw_idle) | msi_request;
	// Reads stall while record or message writes are in flight
	assign bus_rd = psel & penable & ~pwrite & ~mem_busy;
	assign bus_wr = psel & penable & pwrite;
	assign new_region = bus_wr & (paddr == fault_log_pkg::off_log_control)
		& pwdata[fault_log_pkg::ctl_new_region_bit];
	assign st_w1c = (bus_wr & (paddr == fault_log_pkg::off_fault_status))
		? pwdata[st_width-1:0] : '0;
	assign mask_wr = bus_wr & (paddr == fault_log_pkg::off_event_ctrl);

	// Decodes whether an address holds a register
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a <= fault_log_pkg::off_log_index) && (a[1:0] == 2'b00);
	endfunction

	// APB answer: writes in one access cycle, reads once memory is quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~pready & (pwrite | ~mem_busy)
				& (penable | bus_setup);
			pslverr <= psel & ~pready & (pwrite | ~mem_busy)
				& (penable | bus_setup) & ~mapped(paddr);
		end
	end

	// Read data mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= fault_log_pkg::zero_word;
		end else if (psel & ~pwrite & ~pready & ~mem_busy) begin
			case (paddr)
			fault_log_pkg::off_capability: begin
				prdata <= fault_log_pkg::zero_word;
				prdata[fault_log_pkg::cap_mem_log_bit]  <= 1'b1;
				prdata[fault_log_pkg::cap_compress_bit] <= HAS_COMPRESS;
			end
			fault_log_pkg::off_log_control:
				prdata <= {31'h0000_0000, log_enable};
			fault_log_pkg::off_log_base:   prdata <= log_base;
			fault_log_pkg::off_log_size:
				prdata <= 32'(log_size);
			fault_log_pkg::off_fault_status:
				prdata <= 32'(status);
			fault_log_pkg::off_event_ctrl: begin
				prdata <= fault_log_pkg::zero_word;
				prdata[fault_log_pkg::ev_irq_mask_bit] <= irq_mask;
				prdata[fault_log_pkg::ev_irq_held_pending_bit] <=
					irq_held_pending;
			end
			fault_log_pkg::off_event_data: prdata <= ev_data;
			fault_log_pkg::off_event_addr: prdata <= ev_addr;
			fault_log_pkg::off_log_index:
				prdata <= {15'h0000, log_wrapped, 16'(log_index)};
			default: prdata <= fault_log_pkg::zero_word;
			endcase
		end
	end

	// Software configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			log_enable <= 1'b0;
			log_base   <= fault_log_pkg::log_base_reset;
			log_size   <= IDX_W'(fault_log_pkg::log_size_reset);
			ev_data    <= fault_log_pkg::zero_word;
			ev_addr    <= fault_log_pkg::zero_word;
		end else if (bus_wr & pready) begin
			case (paddr)
			fault_log_pkg::off_log_control:
				log_enable <= pwdata[fault_log_pkg::ctl_log_enable_bit];
			fault_log_pkg::off_log_base: log_base <= pwdata;
			fault_log_pkg::off_log_size:
				log_size <= (pwdata[IDX_W-1:0] == '0) ?
					IDX_W'(fault_log_pkg::log_size_reset) : pwdata[IDX_W-1:0];
			fault_log_pkg::off_event_data: ev_data <= pwdata;
			fault_log_pkg::off_event_addr: ev_addr <= pwdata;
			default: ;
			endcase
		end
	end

	// ==========================================================
	// Fault decision
	logic fault_drop_ovf;
	logic fault_drop_rep;
	logic fault_full;
	logic fault_log;
	logic fault_first;
	logic [IDX_W-1:0] next_index;

	assign fault_drop_ovf = status[fault_log_pkg::st_mem_log_overflow_bit];
	assign fault_drop_rep = HAS_COMPRESS & sid_valid & (fault_sid == last_sid);
	assign fault_full = log_wrapped;
	// Faults are taken only while idle and enabled
	assign fault_log = fault_valid & log_enable
		& (mem_state == fault_log_pkg::mw_idle)
		& ~fault_drop_ovf & ~fault_drop_rep & ~fault_full;
	assign fault_first = fault_log
		& ~status[fault_log_pkg::st_mem_log_pending_bit]
		& (log_index == '0);
	assign next_index = (log_index + 1'b1 == log_size) ? '0 : log_index + 1'b1;

	// Index, wrap and last source id
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			log_index   <= '0;
			log_wrapped <= 1'b0;
			sid_valid   <= 1'b0;
			last_sid    <= '0;
		end else if (new_region & pready) begin
			log_index   <= '0;
			log_wrapped <= 1'b0;
			sid_valid   <= 1'b0;
			last_sid    <= '0;
		end else if (fault_log) begin
			log_index   <= next_index;
			log_wrapped <= (log_index + 1'b1 == log_size);
			sid_valid   <= 1'b1;
			last_sid    <= fault_sid;
		end
	end

	// ==========================================================
	// Status flags, hardware set wins over software clear
	logic [st_width-1:0] st_set;
	logic [st_width-1:0] st_mon;
	logic any_new;
	logic any_old;

	always_comb begin
		st_set = '0;
		st_set[fault_log_pkg::st_primary_pending_bit]      = primary_pending_set;
		st_set[fault_log_pkg::st_primary_overflow_bit]     = primary_overflow_set;
		st_set[fault_log_pkg::st_mem_log_pending_bit]      = fault_first;
		st_set[fault_log_pkg::st_mem_log_overflow_bit]     = fault_valid
			& log_enable & (mem_state == fault_log_pkg::mw_idle)
			& ~fault_drop_ovf & ~fault_drop_rep & fault_full;
		st_set[fault_log_pkg::st_inval_queue_err_bit]      = inval_queue_set;
		st_set[fault_log_pkg::st_inval_completion_err_bit] = inval_completion_set;
		st_set[fault_log_pkg::st_inval_timeout_err_bit]    = inval_timeout_set;
	end

	// Memory log flags count only while memory logging is active
	always_comb begin
		st_mon = status;
		st_mon[fault_log_pkg::st_mem_log_pending_bit] =
			status[fault_log_pkg::st_mem_log_pending_bit] & log_enable;
		st_mon[fault_log_pkg::st_mem_log_overflow_bit] =
			status[fault_log_pkg::st_mem_log_overflow_bit] & log_enable;
	end

	assign any_new = |(st_set & ~status
		& ~(st_width'(1) << fault_log_pkg::st_primary_overflow_bit)
		& ~(st_width'(1) << fault_log_pkg::st_mem_log_overflow_bit));
	assign any_old = |st_mon;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
		end else begin
			status <= (status & ~(st_w1c & {st_width{pready}})) | st_set;
		end
	end

	// ==========================================================
	// Event control: mask, held flag and message request
	logic mask_clearing;
	logic status_cleared;

	assign mask_clearing = mask_wr & pready & irq_mask
		& ~pwdata[fault_log_pkg::ev_irq_mask_bit];
	assign status_cleared = (status != '0)
		& ((status & ~(st_w1c & {st_width{pready}})) == '0) & (st_set == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask         <= 1'b1;
			irq_held_pending <= 1'b0;
			msi_request      <= 1'b0;
		end else begin
			// Message taken; a new event in the same cycle wins below
			if (mem_state == fault_log_pkg::mw_msi && mem_ready)
				msi_request <= 1'b0;
			if (mask_wr & pready)
				irq_mask <= pwdata[fault_log_pkg::ev_irq_mask_bit];
			if (any_new & ~any_old) begin
				if (irq_mask & ~mask_clearing) begin
					irq_held_pending <= 1'b1;
				end else begin
					irq_held_pending <= 1'b0;
					msi_request      <= 1'b1;
				end
			end else if (mask_clearing & irq_held_pending) begin
				irq_held_pending <= 1'b0;
				msi_request      <= 1'b1;
			end else if (status_cleared & irq_held_pending) begin
				irq_held_pending <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Memory write engine: one record or one message at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_state  <= fault_log_pkg::mw_idle;
			mem_valid  <= 1'b0;
			mem_addr   <= fault_log_pkg::zero_word;
			mem_data   <= fault_log_pkg::zero_word;
			mem_is_msi <= 1'b0;
		end else begin
			case (mem_state)
			fault_log_pkg::mw_idle: begin
				if (fault_log) begin
					mem_state  <= fault_log_pkg::mw_write;
					mem_valid  <= 1'b1;
					mem_addr   <= log_base
						+ 32'(log_index) * RECORD_BYTES;
					mem_data   <= 32'(fault_sid);
					mem_is_msi <= 1'b0;
				end else if (msi_request) begin
					mem_state  <= fault_log_pkg::mw_msi;
					mem_valid  <= 1'b1;
					mem_addr   <= ev_addr;
					mem_data   <= ev_data;
					mem_is_msi <= 1'b1;
				end
			end
			fault_log_pkg::mw_write, fault_log_pkg::mw_msi: begin
				if (mem_ready) begin
					mem_state <= fault_log_pkg::mw_idle;
					mem_valid <= 1'b0;
				end
			end
			default: mem_state <= fault_log_pkg::mw_idle;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	property p_drop_ovf;
		@(posedge pclk) disable iff (!presetn)
		fault_valid & status[fault_log_pkg::st_mem_log_overflow_bit]
			|=> !(mem_valid & !mem_is_msi & $rose(mem_valid));
	endproperty
	a_drop_ovf: assert property (p_drop_ovf)
		else $error("fault written while overflow set");

	property p_drop_rep;
		@(posedge pclk) disable iff (!presetn)
		fault_valid & fault_drop_rep & (mem_state == fault_log_pkg::mw_idle)
			& !msi_request |=> !mem_valid;
	endproperty
	a_drop_rep: assert property (p_drop_rep)
		else $error("repeated source id logged");

	property p_full_sets_ovf;
		@(posedge pclk) disable iff (!presetn)
		fault_valid & log_enable & (mem_state == fault_log_pkg::mw_idle)
			& ~fault_drop_ovf & ~fault_drop_rep & log_wrapped
			|=> status[fault_log_pkg::st_mem_log_overflow_bit] & !mem_valid;
	endproperty
	a_full_sets_ovf: assert property (p_full_sets_ovf)
		else $error("full log did not set overflow");

	property p_index_step;
		@(posedge pclk) disable iff (!presetn)
		fault_log & !(new_region & pready) |=> log_index == $past(next_index)
			##0 mem_valid & !mem_is_msi;
	endproperty
	a_index_step: assert property (p_index_step)
		else $error("index did not step with record");

	property p_first_pending;
		@(posedge pclk) disable iff (!presetn)
		fault_first |=> status[fault_log_pkg::st_mem_log_pending_bit];
	endproperty
	a_first_pending: assert property (p_first_pending)
		else $error("pending flag not set on first record");

	property p_new_region;
		@(posedge pclk) disable iff (!presetn)
		new_region & pready |=> log_index == '0 && !log_wrapped && !sid_valid;
	endproperty
	a_new_region: assert property (p_new_region)
		else $error("new region did not clear log state");

	property p_masked_held;
		@(posedge pclk) disable iff (!presetn)
		any_new & ~any_old & irq_mask & ~mask_clearing
			|=> irq_held_pending & !msi_request;
	endproperty
	a_masked_held: assert property (p_masked_held)
		else $error("masked event not held");

	property p_unmask_send;
		@(posedge pclk) disable iff (!presetn)
		mask_clearing & irq_held_pending & ~(any_new & ~any_old)
			|=> !irq_held_pending ##[1:300] (mem_valid & mem_is_msi);
	endproperty
	a_unmask_send: assert property (p_unmask_send)
		else $error("unmask did not send held event");

	property p_read_quiet;
		@(posedge pclk) disable iff (!presetn)
		psel & penable & pready & !pwrite |-> !mem_valid;
	endproperty
	a_read_quiet: assert property (p_read_quiet)
		else $error("read completed with writes in flight");

	c_record: cover property (@(posedge pclk) disable iff (!presetn)
		fault_first);
	c_overflow: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(status[fault_log_pkg::st_mem_log_overflow_bit]));
	c_msi: cover property (@(posedge pclk) disable iff (!presetn)
		mem_valid & mem_is_msi & mem_ready);

endmodule

// file: sim/mem_partner.sv
/*
 * Memory and interrupt delivery stand-in for the fault log block.
 * Assumes the block holds mem_valid with a stable payload until it sees
 * mem_ready; the bench sets the number of stall cycles through delay.
 */
module mem_partner (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Write port from the block
	input  wire logic        mem_valid,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_data,
	input  wire logic        mem_is_msi,
	output logic             mem_ready,
	// Bench controls and observations
	input  wire logic [3:0]  delay,
	output logic [7:0]       n_rec,
	output logic [7:0]       n_msi,
	output logic [31:0]      rec_addr,
	output logic [31:0]      rec_data,
	output logic [31:0]      msi_addr,
	output logic [31:0]      msi_data
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] wait_cnt;

	// ==========================================================
	// Stall for delay plus one cycles, then accept one write for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ready <= 1'b0;
			wait_cnt  <= 4'h0;
			n_rec     <= 8'h00;
			n_msi     <= 8'h00;
			rec_addr  <= 32'h0000_0000;
			rec_data  <= 32'h0000_0000;
			msi_addr  <= 32'h0000_0000;
			msi_data  <= 32'h0000_0000;
		end else if (mem_valid && mem_ready) begin
			mem_ready <= 1'b0;
			wait_cnt  <= 4'h0;
			// Messages go to the delivery path as sent, no remap
			if (mem_is_msi) begin
				n_msi    <= n_msi + 8'h01;
				msi_addr <= mem_addr;
				msi_data <= mem_data;
			end else begin
				n_rec    <= n_rec + 8'h01;
				rec_addr <= mem_addr;
				rec_data <= mem_data;
			end
		end else if (mem_valid) begin
			if (wait_cnt >= delay) begin
				mem_ready <= 1'b1;
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule

// file: sim/testbench.sv
/*
 * Self-checking bench for the fault log and event reporter.
 * Assumes the design package is compiled first and mem_partner stands
 * on the memory write port.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] rb   = 32'h0000_0010;
	localparam logic [31:0] base = 32'h0010_0000;
	localparam logic [31:0] eva  = 32'hFEE0_0000;
	localparam logic [31:0] evd  = 32'h0000_0041;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        fault_valid, mem_valid, mem_is_msi, mem_ready, err_v;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_data, rd_v;
	logic [31:0] rec_addr, rec_data, msi_addr, msi_data;
	logic [15:0] fault_sid;
	logic [4:0]  set_v;
	logic [3:0]  delay;
	logic [7:0]  n_rec, n_msi, er, em;
	int          fails, check_count;

	// ==========================================================
	// Design and memory model
	fault_log_and_event_reporter #(.RECORD_BYTES(rb)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fault_valid(fault_valid),
		.fault_sid(fault_sid), .primary_pending_set(set_v[0]),
		.inval_queue_set(set_v[1]), .inval_completion_set(set_v[2]),
		.inval_timeout_set(set_v[3]), .primary_overflow_set(set_v[4]),
		.mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
		.mem_is_msi(mem_is_msi), .mem_ready(mem_ready));

	mem_partner partner (
		.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .mem_data(mem_data), .mem_is_msi(mem_is_msi),
		.mem_ready(mem_ready), .delay(delay), .n_rec(n_rec), .n_msi(n_msi),
		.rec_addr(rec_addr), .rec_data(rec_data), .msi_addr(msi_addr),
		.msi_data(msi_data));

	// Clock at 40 MHz
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string s, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic cnt;
		chk("records", {24'h0, n_rec}, {24'h0, er});
		chk("messages", {24'h0, n_msi}, {24'h0, em});
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) fails++;
		rd_v  = prdata;
		err_v = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string s);
		apb(1'b0, a, 32'h0000_0000);
		chk(s, rd_v, e);
	endtask

	// Wait until the write port has been idle for a while
	task automatic quiet;
		int q, n;
		q = 0;
		n = 0;
		while (q < 6 && n < 400) begin
			@(posedge pclk);
			n++;
			q = mem_valid ? 0 : q + 1;
		end
	endtask

	task automatic fault(input logic [15:0] sid);
		@(posedge pclk);
		fault_valid <= 1'b1;
		fault_sid   <= sid;
		@(posedge pclk);
		fault_valid <= 1'b0;
		quiet;
	endtask

	task automatic pulse(input int i);
		@(posedge pclk);
		set_v[i] <= 1'b1;
		@(posedge pclk);
		set_v <= 5'h00;
		quiet;
	endtask

	// Clear status and install a new region, event control as given
	task automatic fresh(input logic [31:0] ev);
		wr(fault_log_pkg::off_event_ctrl, ev);
		wr(fault_log_pkg::off_fault_status, 32'h0000_007F);
		wr(fault_log_pkg::off_log_control, 32'h0000_0003);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rd(fault_log_pkg::off_capability, 32'h0000_0003, "cap");
		rd(fault_log_pkg::off_log_size, 32'h0000_0001, "size");
		rd(fault_log_pkg::off_event_ctrl, 32'h8000_0000, "ev");
		rd(fault_log_pkg::off_log_index, 32'h0000_0000, "idx");
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk("unmapped err", {31'h0, err_v}, 32'h0000_0001);
		chk("unmapped data", rd_v, 32'h0000_0000);
		wr(fault_log_pkg::off_log_base, base);
		wr(fault_log_pkg::off_log_size, 32'h0000_0004);
		wr(fault_log_pkg::off_event_data, evd);
		wr(fault_log_pkg::off_event_addr, eva);
		fresh(32'h0000_0000);
	endtask

	task automatic t_first;
		fault(16'h0005);
		er = 8'h01;
		em = 8'h01;
		cnt;
		chk("rec addr", rec_addr, base);
		chk("rec data", rec_data, 32'h0000_0005);
		chk("msi addr", msi_addr, eva);
		chk("msi data", msi_data, evd);
		rd(fault_log_pkg::off_fault_status, 32'h0000_0008, "st");
		rd(fault_log_pkg::off_log_index, 32'h0000_0001, "idx");
		rd(fault_log_pkg::off_event_ctrl, 32'h0000_0000, "ev");
	endtask

	task automatic t_compress;
		fault(16'h0005);
		cnt;
		fault(16'h0006);
		er = 8'h02;
		cnt;
		chk("rec addr", rec_addr, base + rb);
		rd(fault_log_pkg::off_log_index, 32'h0000_0002, "idx");
	endtask

	task automatic t_wrap;
		fault(16'h0007);
		fault(16'h0008);
		er = 8'h04;
		apb(1'b0, fault_log_pkg::off_log_index, 32'h0000_0000);
		chk("wrap", {31'h0, rd_v[16]}, 32'h0000_0001);
		fault(16'h0009);
		cnt;
		rd(fault_log_pkg::off_fault_status, 32'h0000_000C, "st");
		fault(16'h000A);
		cnt;
	endtask

	task automatic t_region;
		fresh(32'h0000_0000);
		rd(fault_log_pkg::off_log_index, 32'h0000_0000, "idx");
		fault(16'h0008);
		er = 8'h05;
		em = 8'h02;
		cnt;
		chk("rec addr", rec_addr, base);
	endtask

	task automatic t_mask;
		fresh(32'h8000_0000);
		fault(16'h0003);
		er = 8'h06;
		cnt;
		rd(fault_log_pkg::off_event_ctrl, 32'hC000_0000, "ev");
		wr(fault_log_pkg::off_event_ctrl, 32'h0000_0000);
		quiet;
		em = 8'h03;
		cnt;
		rd(fault_log_pkg::off_event_ctrl, 32'h0000_0000, "ev");
	endtask

	task automatic t_silent;
		fresh(32'h8000_0000);
		fault(16'h0004);
		er = 8'h07;
		wr(fault_log_pkg::off_fault_status, 32'h0000_007F);
		rd(fault_log_pkg::off_event_ctrl, 32'h8000_0000, "ev");
		wr(fault_log_pkg::off_event_ctrl, 32'h0000_0000);
		quiet;
		cnt;
	endtask

	// Each input trigger source, first blocked by an open overflow flag
	task automatic t_sources;
		for (int i = 0; i < 4; i++) begin
			fresh(32'h0000_0000);
			pulse(4);
			pulse(i);
			cnt;
			fresh(32'h0000_0000);
			pulse(i);
			em++;
			cnt;
		end
	endtask

	// Slow memory: reads must not finish ahead of issued writes
	task automatic t_commit;
		delay <= 4'hC;
		fresh(32'h0000_0000);
		@(posedge pclk);
		fault_valid <= 1'b1;
		fault_sid   <= 16'h000C;
		@(posedge pclk);
		fault_valid <= 1'b0;
		er++;
		rd(fault_log_pkg::off_log_index, 32'h0000_0001, "idx");
		em++;
		cnt;
		rd(fault_log_pkg::off_fault_status, 32'h0000_0008, "st");
		cnt;
		quiet;
		delay <= 4'h0;
	endtask

	task automatic give_verdict;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		fault_valid = 1'b0;
		fault_sid = 16'h0000;
		set_v = 5'h00;
		delay = 4'h0;
		er = 8'h00;
		em = 8'h00;
		fails = 0;
		check_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_first;
		t_compress;
		t_wrap;
		t_region;
		t_mask;
		t_silent;
		t_sources;
		t_commit;
		give_verdict;
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		give_verdict;
	end
endmodule
